//--- verilog/citsf_pkg.sv
// Package for the module-side transport connection state machine
package citsf_pkg;
  localparam int CITSF_ID_W = 8;
  localparam logic [7:0] CITSF_ID_NONE = 8'h00;
  // Session units ride opaquely inside data objects; framing kept for the upper layer
  localparam int CITSF_TAG_W = 8;
  localparam logic [7:0] CITSF_LEN_SHORT_MAX = 8'h7F;
  localparam int CITSF_LEN_FLAG_BIT = 7;
  localparam logic [7:0] CITSF_STATUS_PENDING = 8'h80;
  localparam logic [7:0] CITSF_STATUS_IDLE = 8'h00;

  typedef enum logic [3:0] {
    CITSF_OBJ_CREATE_CMD = 4'h1,
    CITSF_OBJ_CREATE_ACK = 4'h2,
    CITSF_OBJ_DELETE_CMD = 4'h3,
    CITSF_OBJ_DELETE_ACK = 4'h4,
    CITSF_OBJ_CONN_REQUEST = 4'h5,
    CITSF_OBJ_NEW_CONN_NOTICE = 4'h6,
    CITSF_OBJ_CONN_ERROR = 4'h7,
    CITSF_OBJ_STATUS = 4'h8,
    CITSF_OBJ_RECEIVE_REQUEST = 4'h9,
    CITSF_OBJ_DATA_MORE = 4'hA,
    CITSF_OBJ_DATA_LAST = 4'hB
  } citsf_obj_t;

  typedef enum logic [1:0] {
    CITSF_ST_IDLE = 2'b00,
    CITSF_ST_ACTIVE = 2'b01,
    CITSF_ST_IN_DELETION = 2'b10
  } citsf_state_t;

  typedef struct packed {
    citsf_obj_t kind;
    logic [7:0] conn_id;
  } citsf_obj_hdr_t;

  typedef struct packed {
    citsf_obj_t first_kind;
    logic first_valid;
    citsf_obj_t second_kind;
    logic [7:0] conn_id;
    logic [7:0] status;
  } citsf_reply_t;
endpackage : citsf_pkg

//--- verilog/citsf_module_fsm.sv
// Module-side transport connection state machine for one connection
// Overview of operation
// - In Idle or Active, module answers create_connection_cmd at once with create_connection_ack, same id.
// - A create_connection_cmd while Active, whatever its id, restarts the connection fresh.
// - Outside Active, unexpected objects are silently ignored.
// - Active replies carry status, optionally preceded by an ack, data, request or delete.
// - Module never sends data unprompted; it flags pending data in status.
// - Module answers receive_request with waiting data in a data object.
// - Each further fragment waits for another receive_request.
// - Module accepts only the objects listed for its current state.
// - Connection requests go out only in reply to poll or data.
// - Session header: 8-bit tag, length, value; length excludes application units.
// - Body presence depends on header type; whole application units only.
// - Length uses size flag: short form up to 127, else byte count.
// - Connection identifier is one octet; zero is never used.
`timescale 1ns/1ns
`default_nettype none
module citsf_module_fsm
  import citsf_pkg::*;
(
  input wire logic REF_CLK, // 10 MHz clock
  input wire logic SYS_RST, // Async reset, active high
  input wire logic RX_VALID, // Host object present
  input wire citsf_pkg::citsf_obj_hdr_t RX_HDR, // Host object kind and id
  output logic RX_READY, // Object taken
  output logic TX_VALID, // Reply present
  output citsf_pkg::citsf_reply_t TX_REPLY, // Reply objects
  input wire logic TX_READY, // Reply taken by link
  input wire logic APP_DATA_PEND, // Upper layer has a unit waiting
  input wire logic APP_DATA_MORE, // Next fragment is not the last
  output logic APP_FRAG_SENT, // One fragment handed to link
  input wire logic APP_WANT_CONN, // Upper layer wants a new connection
  output logic APP_CONN_REQ_SENT, // Connection request sent
  input wire logic APP_WANT_DELETE, // Upper layer wants deletion
  output logic [7:0] CONN_ID, // Current connection id
  output logic CONN_ACTIVE, // Connection in Active
  output logic CONN_RESTART // Pulse: connection re-created
);
  import citsf_pkg::*;

  citsf_state_t state_r, state_nxt;
  logic [7:0] id_r, id_nxt;
  logic tx_valid_r, tx_valid_nxt;
  citsf_reply_t reply_r, reply_nxt;
  logic frag_r, frag_nxt;
  logic connreq_r, connreq_nxt;
  logic restart_r, restart_nxt;

  wire logic take = RX_VALID && RX_READY;
  wire logic id_ok = RX_HDR.conn_id != CITSF_ID_NONE;
  wire logic is_create = RX_HDR.kind == CITSF_OBJ_CREATE_CMD;
  wire logic is_poll_data = RX_HDR.kind == CITSF_OBJ_DATA_LAST || RX_HDR.kind == CITSF_OBJ_DATA_MORE;
  wire logic is_rcv = RX_HDR.kind == CITSF_OBJ_RECEIVE_REQUEST;
  wire logic is_del = RX_HDR.kind == CITSF_OBJ_DELETE_CMD;
  wire logic is_del_ack = RX_HDR.kind == CITSF_OBJ_DELETE_ACK;
  wire logic is_other_active = RX_HDR.kind == CITSF_OBJ_NEW_CONN_NOTICE ||
                               RX_HDR.kind == CITSF_OBJ_CONN_ERROR;
  wire logic same_id = RX_HDR.conn_id == id_r;
  wire logic [7:0] status_now = APP_DATA_PEND ? CITSF_STATUS_PENDING : CITSF_STATUS_IDLE;

  // Stall intake while a reply waits: one object, one reply, in order
  assign RX_READY = !tx_valid_r;
  assign TX_VALID = tx_valid_r;
  assign TX_REPLY = reply_r;
  assign CONN_ID = id_r;
  assign CONN_ACTIVE = state_r == CITSF_ST_ACTIVE;
  assign APP_FRAG_SENT = frag_r;
  assign APP_CONN_REQ_SENT = connreq_r;
  assign CONN_RESTART = restart_r;

  always_comb begin
    state_nxt = state_r;
    id_nxt = id_r;
    tx_valid_nxt = tx_valid_r && !TX_READY;
    reply_nxt = reply_r;
    frag_nxt = 1'b0;
    connreq_nxt = 1'b0;
    restart_nxt = 1'b0;
    if (take && id_ok) begin
      unique case (state_r)
        CITSF_ST_IDLE: begin
          if (is_create) begin
            state_nxt = CITSF_ST_ACTIVE;
            id_nxt = RX_HDR.conn_id;
            tx_valid_nxt = 1'b1;
            reply_nxt = '{first_kind: CITSF_OBJ_CREATE_ACK, first_valid: 1'b1,
                          second_kind: CITSF_OBJ_STATUS, conn_id: RX_HDR.conn_id,
                          status: status_now};
          end
        end
        CITSF_ST_ACTIVE: begin
          if (is_create) begin
            // Old connection is presumed dead
            id_nxt = RX_HDR.conn_id;
            restart_nxt = 1'b1;
            tx_valid_nxt = 1'b1;
            reply_nxt = '{first_kind: CITSF_OBJ_CREATE_ACK, first_valid: 1'b1,
                          second_kind: CITSF_OBJ_STATUS, conn_id: RX_HDR.conn_id,
                          status: status_now};
          end else if (same_id && is_rcv && APP_DATA_PEND) begin
            // One fragment per receive request
            tx_valid_nxt = 1'b1;
            frag_nxt = 1'b1;
            reply_nxt = '{first_kind: APP_DATA_MORE ? CITSF_OBJ_DATA_MORE : CITSF_OBJ_DATA_LAST,
                          first_valid: 1'b1, second_kind: CITSF_OBJ_STATUS,
                          conn_id: id_r, status: status_now};
          end else if (same_id && is_del) begin
            // Host-initiated delete: acknowledge, back to Idle
            state_nxt = CITSF_ST_IDLE;
            tx_valid_nxt = 1'b1;
            reply_nxt = '{first_kind: CITSF_OBJ_DELETE_ACK, first_valid: 1'b1,
                          second_kind: CITSF_OBJ_STATUS, conn_id: id_r,
                          status: CITSF_STATUS_IDLE};
          end else if (same_id && (is_poll_data || is_rcv || is_other_active)) begin
            tx_valid_nxt = 1'b1;
            reply_nxt = '{first_kind: CITSF_OBJ_STATUS, first_valid: 1'b0,
                          second_kind: CITSF_OBJ_STATUS, conn_id: id_r,
                          status: status_now};
            if (is_poll_data && APP_WANT_DELETE) begin
              state_nxt = CITSF_ST_IN_DELETION;
              reply_nxt.first_kind = CITSF_OBJ_DELETE_CMD;
              reply_nxt.first_valid = 1'b1;
            end else if (is_poll_data && APP_WANT_CONN) begin
              connreq_nxt = 1'b1;
              reply_nxt.first_kind = CITSF_OBJ_CONN_REQUEST;
              reply_nxt.first_valid = 1'b1;
            end
          end
        end
        CITSF_ST_IN_DELETION: begin
          if (is_del_ack && same_id) begin
            state_nxt = CITSF_ST_IDLE;
          end
        end
        default: state_nxt = CITSF_ST_IDLE;
      endcase
    end
  end

  always_ff @(posedge REF_CLK or posedge SYS_RST) begin
    if (SYS_RST) begin
      state_r <= CITSF_ST_IDLE;
      id_r <= CITSF_ID_NONE;
      tx_valid_r <= 1'b0;
      reply_r <= '0;
      frag_r <= 1'b0;
      connreq_r <= 1'b0;
      restart_r <= 1'b0;
    end else begin
      state_r <= state_nxt;
      id_r <= id_nxt;
      tx_valid_r <= tx_valid_nxt;
      reply_r <= reply_nxt;
      frag_r <= frag_nxt;
      connreq_r <= connreq_nxt;
      restart_r <= restart_nxt;
    end
  end

  a_create_ack_next: assert property (@(posedge REF_CLK) disable iff (SYS_RST)
    (take && id_ok && is_create && state_r != CITSF_ST_IN_DELETION) |=>
      (TX_VALID && TX_REPLY.first_kind == CITSF_OBJ_CREATE_ACK && TX_REPLY.conn_id == $past(RX_HDR.conn_id)))
    else $error("create cmd not acked next cycle");
  a_restart_pulse: assert property (@(posedge REF_CLK) disable iff (SYS_RST)
    (take && id_ok && is_create && state_r == CITSF_ST_ACTIVE) |=> (CONN_RESTART && CONN_ACTIVE))
    else $error("re-create did not restart");
  a_idle_ignores: assert property (@(posedge REF_CLK) disable iff (SYS_RST)
    (take && state_r == CITSF_ST_IDLE && !is_create) |=> (!TX_VALID && state_r == CITSF_ST_IDLE))
    else $error("idle reacted to unexpected object");
  a_deletion_ack_only: assert property (@(posedge REF_CLK) disable iff (SYS_RST)
    (state_r == CITSF_ST_IN_DELETION && take && !is_del_ack) |=> (state_r == CITSF_ST_IN_DELETION && !TX_VALID))
    else $error("in deletion accepted wrong object");
  a_status_last: assert property (@(posedge REF_CLK) disable iff (SYS_RST)
    TX_VALID |-> (TX_REPLY.second_kind == CITSF_OBJ_STATUS))
    else $error("reply not closed by status");
  a_pending_flag: assert property (@(posedge REF_CLK) disable iff (SYS_RST)
    (take && id_ok && state_r == CITSF_ST_ACTIVE && same_id && is_poll_data) |=>
      (TX_VALID && TX_REPLY.status == ($past(APP_DATA_PEND) ? CITSF_STATUS_PENDING : CITSF_STATUS_IDLE)))
    else $error("status flag wrong");
  a_data_only_on_rcv: assert property (@(posedge REF_CLK) disable iff (SYS_RST)
    $rose(APP_FRAG_SENT) |-> ($past(is_rcv) && $past(take)))
    else $error("data sent without receive request");
  a_one_frag: assert property (@(posedge REF_CLK) disable iff (SYS_RST)
    APP_FRAG_SENT |=> !APP_FRAG_SENT)
    else $error("two fragments for one request");
  a_connreq_on_poll: assert property (@(posedge REF_CLK) disable iff (SYS_RST)
    APP_CONN_REQ_SENT |-> ($past(is_poll_data) && TX_REPLY.first_kind == CITSF_OBJ_CONN_REQUEST))
    else $error("connection request not on poll");
  a_zero_id_ignored: assert property (@(posedge REF_CLK) disable iff (SYS_RST)
    (take && !id_ok) |=> !TX_VALID)
    else $error("zero id answered");

  // Reply handshake: the reply must stand untouched until the link takes it
  a_reply_holds: assert property (@(posedge REF_CLK) disable iff (SYS_RST)
    (TX_VALID && !TX_READY) |=>
      (TX_VALID && $stable(TX_REPLY)))
    else $error("reply changed before taken");
  a_reply_drops: assert property (@(posedge REF_CLK) disable iff (SYS_RST)
    (TX_VALID && TX_READY) |=>
      !TX_VALID)
    else $error("reply stayed after taken");
  a_reply_same_id: assert property (@(posedge REF_CLK) disable iff (SYS_RST)
    TX_VALID |->
      (TX_REPLY.conn_id == CONN_ID))
    else $error("reply id differs from connection");
  a_status_codes: assert property (@(posedge REF_CLK) disable iff (SYS_RST)
    TX_VALID |->
      (TX_REPLY.status == CITSF_STATUS_PENDING || TX_REPLY.status == CITSF_STATUS_IDLE))
    else $error("status byte has unknown code");
  // Nothing leaves the module unless an object was taken just before
  a_no_unprompted: assert property (@(posedge REF_CLK) disable iff (SYS_RST)
    $rose(TX_VALID) |->
      $past(take))
    else $error("reply without host object");
  a_rcv_no_data: assert property (@(posedge REF_CLK) disable iff (SYS_RST)
    (take && id_ok && CONN_ACTIVE && same_id && is_rcv && !APP_DATA_PEND) |=>
      (TX_VALID && !TX_REPLY.first_valid && !APP_FRAG_SENT))
    else $error("empty receive request not answered by status alone");
  a_data_needs_pend: assert property (@(posedge REF_CLK) disable iff (SYS_RST)
    APP_FRAG_SENT |->
      $past(APP_DATA_PEND))
    else $error("fragment sent with nothing pending");
  a_frag_kind: assert property (@(posedge REF_CLK) disable iff (SYS_RST)
    APP_FRAG_SENT |->
      (TX_VALID && TX_REPLY.first_kind == ($past(APP_DATA_MORE) ? CITSF_OBJ_DATA_MORE : CITSF_OBJ_DATA_LAST)))
    else $error("fragment kind wrong");
  a_restart_id: assert property (@(posedge REF_CLK) disable iff (SYS_RST)
    CONN_RESTART |->
      (CONN_ID == $past(RX_HDR.conn_id)))
    else $error("restart kept old id");
  a_restart_single: assert property (@(posedge REF_CLK) disable iff (SYS_RST)
    CONN_RESTART |=>
      !CONN_RESTART)
    else $error("restart pulse too long");
  a_idle_create: assert property (@(posedge REF_CLK) disable iff (SYS_RST)
    (take && id_ok && is_create && state_r == CITSF_ST_IDLE) |=>
      CONN_ACTIVE)
    else $error("create did not open connection");
  a_host_delete: assert property (@(posedge REF_CLK) disable iff (SYS_RST)
    (take && id_ok && CONN_ACTIVE && same_id && is_del) |=>
      (!CONN_ACTIVE && TX_VALID && TX_REPLY.first_kind == CITSF_OBJ_DELETE_ACK))
    else $error("host delete not acknowledged");
  a_module_delete: assert property (@(posedge REF_CLK) disable iff (SYS_RST)
    (take && id_ok && CONN_ACTIVE && same_id && is_poll_data && APP_WANT_DELETE) |=>
      (state_r == CITSF_ST_IN_DELETION && TX_REPLY.first_kind == CITSF_OBJ_DELETE_CMD))
    else $error("wanted delete not sent");
  a_deletion_exit: assert property (@(posedge REF_CLK) disable iff (SYS_RST)
    (state_r == CITSF_ST_IN_DELETION && take && id_ok && is_del_ack && same_id) |=>
      (state_r == CITSF_ST_IDLE && !TX_VALID))
    else $error("delete ack did not close connection");
  a_other_id_ignored: assert property (@(posedge REF_CLK) disable iff (SYS_RST)
    (take && CONN_ACTIVE && !same_id && !is_create) |=>
      !TX_VALID)
    else $error("object for other id answered");
  // Delete wins over a connection request when both are wanted
  a_connreq_pulse: assert property (@(posedge REF_CLK) disable iff (SYS_RST)
    (take && id_ok && CONN_ACTIVE && same_id && is_poll_data && APP_WANT_CONN && !APP_WANT_DELETE) |=>
      (APP_CONN_REQ_SENT && TX_REPLY.first_kind == CITSF_OBJ_CONN_REQUEST))
    else $error("wanted connection request not sent");
  a_zero_id_state: assert property (@(posedge REF_CLK) disable iff (SYS_RST)
    (take && !id_ok) |=>
      ($stable(state_r) && $stable(CONN_ID)))
    else $error("zero id changed state");
  a_active_id_nonzero: assert property (@(posedge REF_CLK) disable iff (SYS_RST)
    CONN_ACTIVE |->
      (CONN_ID != CITSF_ID_NONE))
    else $error("active with reserved id");

  c_restart: cover property (@(posedge REF_CLK) disable iff (SYS_RST) CONN_RESTART);
  c_create: cover property (@(posedge REF_CLK) disable iff (SYS_RST)
    state_r == CITSF_ST_IDLE ##1 state_r == CITSF_ST_ACTIVE);
  c_fragment: cover property (@(posedge REF_CLK) disable iff (SYS_RST) APP_FRAG_SENT);
  c_connreq: cover property (@(posedge REF_CLK) disable iff (SYS_RST) APP_CONN_REQ_SENT);
  c_module_delete: cover property (@(posedge REF_CLK) disable iff (SYS_RST)
    state_r == CITSF_ST_IN_DELETION ##[1:20] state_r == CITSF_ST_IDLE);
endmodule // citsf_module_fsm
`default_nettype wire

//--- verif/citsf_host_model.sv
// Host-side partner model: sends one object, then takes the reply
`timescale 1ns/1ns
`default_nettype none
module citsf_host_model
  import citsf_pkg::*;
(
  input wire logic clk, // Clock
  input wire logic rx_ready, // Object can be taken
  input wire logic tx_valid, // Reply waiting
  input wire citsf_pkg::citsf_reply_t tx_reply, // Reply objects
  output logic rx_valid, // Object present
  output citsf_pkg::citsf_obj_hdr_t rx_hdr, // Object kind and id
  output logic tx_ready // Reply taken
);
  import citsf_pkg::*;
  // Reply time-out for every object sent, in cycles of waiting for a reply
  localparam int REPLY_WAIT = 4;
  // Session traffic rides opaquely in data objects; routing stays above this model
  initial begin
    rx_valid = 1'b0;
    rx_hdr = '0;
    tx_ready = 1'b0;
  end
  // Code 0 no reply, 1 reply, 2 hung or reply withdrawn
  task automatic send(input citsf_obj_t k, input logic [7:0] id, input int stall,
    output int code, output citsf_reply_t rep);
    logic seen;
    code = 2;
    rep = '0;
    seen = 1'b0;
    @(posedge clk);
    rx_valid <= 1'b1;
    rx_hdr <= '{kind: k, conn_id: id};
    for (int n = 0; n < 20 && !seen; n++) begin
      @(negedge clk) seen = rx_ready;
      @(posedge clk);
    end
    if (!seen) return;
    rx_valid <= 1'b0;
    // Released lines carry junk so a stale object cannot pass
    rx_hdr <= citsf_obj_hdr_t'(~rx_hdr);
    code = 0;
    for (int n = 0; n < REPLY_WAIT && code == 0; n++)
      @(negedge clk) if (tx_valid) code = 1;
    if (code == 0) begin
      @(posedge clk);
      return;
    end
    repeat (stall) @(posedge clk);
    @(posedge clk) tx_ready <= 1'b1;
    @(negedge clk) rep = tx_reply;
    if (!tx_valid) code = 2;
    @(posedge clk) tx_ready <= 1'b0;
  endtask
endmodule // citsf_host_model
`default_nettype wire

//--- verif/citsf_module_fsm_test.sv
// Self-checking bench for the module-side transport state machine
`timescale 1ns/1ns
`default_nettype none
module citsf_module_fsm_test;
  import citsf_pkg::*;
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic rx_valid, rx_ready, tx_valid, tx_ready, frag, req, active, restart, p;
  logic pend = 1'b0, more = 1'b0, want_conn = 1'b0, want_del = 1'b0;
  logic [7:0] conn_id, id;
  logic [31:0] seed = 32'h00000026;
  citsf_obj_hdr_t rx_hdr;
  citsf_reply_t tx_reply, rep;
  int bad_count = 0, comparisons = 0, frags = 0, reqs = 0, restarts = 0, code;
  always #50 clk = ~clk;
  always @(posedge clk) begin
    if (frag === 1'b1) frags++;
    if (req === 1'b1) reqs++;
    if (restart === 1'b1) restarts++;
  end
  citsf_module_fsm DUT (.REF_CLK(clk), .SYS_RST(rst), .RX_VALID(rx_valid), .RX_HDR(rx_hdr),
    .RX_READY(rx_ready), .TX_VALID(tx_valid), .TX_REPLY(tx_reply), .TX_READY(tx_ready),
    .APP_DATA_PEND(pend), .APP_DATA_MORE(more), .APP_FRAG_SENT(frag), .APP_WANT_CONN(want_conn),
    .APP_CONN_REQ_SENT(req), .APP_WANT_DELETE(want_del), .CONN_ID(conn_id),
    .CONN_ACTIVE(active), .CONN_RESTART(restart));
  citsf_host_model host (.clk(clk), .rx_ready(rx_ready), .tx_valid(tx_valid),
    .tx_reply(tx_reply), .rx_valid(rx_valid), .rx_hdr(rx_hdr), .tx_ready(tx_ready));
  function automatic logic [31:0] xs(input logic [31:0] s);
    s ^= s << 13;
    s ^= s >> 17;
    return s ^ (s << 5);
  endfunction
  function automatic logic [7:0] rnd_id();
    seed = xs(seed);
    return (seed[7:0] == 8'h00) ? 8'h01 : seed[7:0];
  endfunction
  // First kind only matters when flagged present
  function automatic logic [24:0] key(input citsf_reply_t r);
    return {r.first_valid ? 4'(r.first_kind) : 4'h0, r.first_valid, 4'(r.second_kind), r.conn_id, r.status};
  endfunction
  task automatic check(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    comparisons++;
    if (seen !== exp) begin
      bad_count++;
      $display("FAIL %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  task automatic final_report();
    $display("comparisons %0d mismatches %0d", comparisons, bad_count);
    if (bad_count == 0 && comparisons > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask
  task automatic xfer(input citsf_obj_t k, input logic [7:0] i);
    seed = xs(seed);
    host.send(k, i, int'(seed[1:0]), code, rep);
    if (code == 2) begin
      bad_count++;
      final_report();
    end
  endtask
  task automatic exp_reply(input logic fv, input citsf_obj_t k, input logic [7:0] st);
    citsf_reply_t e;
    e = '{first_kind: k, first_valid: fv, second_kind: CITSF_OBJ_STATUS, conn_id: id, status: st};
    check("reply", {code[3:0], 3'h0, key(rep)}, {4'h1, 3'h0, key(e)});
  endtask
  initial begin
    repeat (16) @(posedge clk);
    rst <= 1'b0;
    id = 8'h05;
    xfer(CITSF_OBJ_DATA_LAST, id);
    check("idle poll", code, 0);
    xfer(CITSF_OBJ_CREATE_CMD, 8'h00);
    check("zero id", code, 0);
    for (int r = 0; r < 6; r++) begin
      id = rnd_id();
      pend <= 1'b0;
      xfer(CITSF_OBJ_CREATE_CMD, id);
      exp_reply(1'b1, CITSF_OBJ_CREATE_ACK, CITSF_STATUS_IDLE);
      check("conn", {active, conn_id}, {1'b1, id});
      p = seed[9];
      pend <= p;
      xfer(CITSF_OBJ_DATA_LAST, id);
      exp_reply(1'b0, CITSF_OBJ_STATUS, p ? CITSF_STATUS_PENDING : CITSF_STATUS_IDLE);
    end
    check("restarts", restarts, 5);
    xfer(CITSF_OBJ_DATA_LAST, {~id[7], id[6:1], 1'b1});
    check("other id", code, 0);
    pend <= 1'b1;
    more <= 1'b1;
    xfer(CITSF_OBJ_RECEIVE_REQUEST, id);
    exp_reply(1'b1, CITSF_OBJ_DATA_MORE, CITSF_STATUS_PENDING);
    more <= 1'b0;
    xfer(CITSF_OBJ_RECEIVE_REQUEST, id);
    exp_reply(1'b1, CITSF_OBJ_DATA_LAST, CITSF_STATUS_PENDING);
    pend <= 1'b0;
    xfer(CITSF_OBJ_RECEIVE_REQUEST, id);
    exp_reply(1'b0, CITSF_OBJ_STATUS, CITSF_STATUS_IDLE);
    check("frags", frags, 2);
    xfer(CITSF_OBJ_DATA_MORE, id);
    exp_reply(1'b0, CITSF_OBJ_STATUS, CITSF_STATUS_IDLE);
    want_conn <= 1'b1;
    xfer(CITSF_OBJ_RECEIVE_REQUEST, id);
    exp_reply(1'b0, CITSF_OBJ_STATUS, CITSF_STATUS_IDLE);
    xfer(CITSF_OBJ_DATA_LAST, id);
    exp_reply(1'b1, CITSF_OBJ_CONN_REQUEST, CITSF_STATUS_IDLE);
    xfer(CITSF_OBJ_NEW_CONN_NOTICE, id);
    exp_reply(1'b0, CITSF_OBJ_STATUS, CITSF_STATUS_IDLE);
    id = rnd_id();
    xfer(CITSF_OBJ_CREATE_CMD, id);
    exp_reply(1'b1, CITSF_OBJ_CREATE_ACK, CITSF_STATUS_IDLE);
    xfer(CITSF_OBJ_CONN_ERROR, id);
    exp_reply(1'b0, CITSF_OBJ_STATUS, CITSF_STATUS_IDLE);
    want_del <= 1'b1;
    xfer(CITSF_OBJ_DATA_LAST, id);
    exp_reply(1'b1, CITSF_OBJ_DELETE_CMD, CITSF_STATUS_IDLE);
    want_del <= 1'b0;
    want_conn <= 1'b0;
    check("reqs", {reqs[3:0], active}, {4'h1, 1'b0});
    xfer(CITSF_OBJ_DATA_LAST, id);
    check("deleting poll", code, 0);
    xfer(CITSF_OBJ_DELETE_ACK, id);
    check("delete ack", code, 0);
    id = rnd_id();
    xfer(CITSF_OBJ_CREATE_CMD, id);
    exp_reply(1'b1, CITSF_OBJ_CREATE_ACK, CITSF_STATUS_IDLE);
    xfer(CITSF_OBJ_DELETE_CMD, id);
    exp_reply(1'b1, CITSF_OBJ_DELETE_ACK, CITSF_STATUS_IDLE);
    xfer(CITSF_OBJ_DATA_LAST, id);
    check("after delete", {active, code[3:0]}, 5'h00);
    final_report();
  end
endmodule // citsf_module_fsm_test
`default_nettype wire
